/* File: inc/pft_pkg.sv */
// Constants shared by the frame timestamping unit
package pft_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned STAMP_W  = 32;
  localparam int unsigned SEQ_W    = 4;
  localparam int unsigned STAT_W   = 8;
  localparam int unsigned AXI_AW   = 8;
  localparam int unsigned AXI_DW   = 32;
  localparam int unsigned AXI_SW   = AXI_DW / 8;
  localparam int unsigned EVT_W    = 2;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_EVENT_FLAGS = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_EVENT_MASK  = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_HELD_STAMP  = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_TIMER_NOW   = 8'h0c;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned EVT_STAMP_READY = 0;
  localparam int unsigned EVT_TIMER       = 1;
  localparam int unsigned STAT_FLAGGED    = 5;
  localparam logic [EVT_W-1:0]   EVT_RST   = 2'h0;
  localparam logic [EVT_W-1:0]   MASK_RST  = 2'h0;
  localparam logic [STAMP_W-1:0] STAMP_RST = 32'h0000_0000;
  localparam logic [STAMP_W-1:0] STAMP_MAX = 32'hffff_ffff;
  localparam logic [STAMP_W-1:0] STAMP_ONE = 32'h0000_0001;
  localparam logic [SEQ_W-1:0]   SEQ_RST   = 4'h0;
  localparam logic [STAT_W-1:0]  STAT_RST  = 8'h00;

  // ---------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pft_pkg

/* File: inc/pft_tmr_if.sv */
// Carrier between the free-running timer and the stamping logic
`timescale 1ns/1ps
interface pft_tmr_if;
  import pft_pkg::*;

  logic [STAMP_W-1:0] count;
  logic               wrap;

  modport tmr  (output count, output wrap);
  modport user (input  count, input  wrap);
endinterface : pft_tmr_if

/* File: rtl/pft_timer.sv */
// Free-running stamp timer with wrap event
`timescale 1ns/1ps
module pft_timer
  import pft_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic aclk_en,
  // Timer outputs
  pft_tmr_if.tmr    tmr
);

  logic [STAMP_W-1:0] count_q, count_d;
  logic               wrap_q,  wrap_d;

  always_comb begin
    count_d = count_q + STAMP_ONE;
    // Pulse in the cycle the count reads zero again
    wrap_d  = (count_q == STAMP_MAX);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= STAMP_RST;
      wrap_q  <= 1'b0;
    end else if (aclk_en) begin
      count_q <= count_d;
      wrap_q  <= wrap_d;
    end
  end

  assign tmr.count = count_q;
  assign tmr.wrap  = wrap_q;

endmodule : pft_timer

/* File: rtl/pft_stamp.sv */
// Frame timestamping unit: transmit and receive stamps, events, AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Every sent frame returns its 32-bit stamp, 4-bit sequence and status.
// - Status bit 5 is set only when that frame carried the request.
// - A requested frame's stamp is also stored in the held-stamp register.
// - Storing a held stamp sets the stamp-ready flag.
// - Unrequested frames neither overwrite the held stamp nor set stamp-ready.
// - Every received frame latches the timer at delimiter detection.
// - Stamp-ready and timer events share one interrupt output.
module pft_stamp
  import pft_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               aclk_en,

  // AXI4-Lite write address
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [AXI_DW-1:0]  s_axi_wdata,
  input  wire logic [AXI_SW-1:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [AXI_AW-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  // AXI4-Lite read data
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [AXI_DW-1:0]       s_axi_rdata,
  output logic [1:0]              s_axi_rresp,

  // Transmit side from the MAC client
  input  wire logic               tx_sfd,
  input  wire logic               tx_stamp_request,
  input  wire logic [SEQ_W-1:0]   tx_frame_seq,
  input  wire logic               tx_frame_end,
  input  wire logic [STAT_W-1:0]  tx_frame_status,
  // Transmit stamp return
  output logic                    tx_stamp_valid,
  output logic [STAMP_W-1:0]      tx_stamp_value,
  output logic [SEQ_W-1:0]        tx_stamp_seq,
  output logic [STAT_W-1:0]       tx_stamp_status,

  // Receive side
  input  wire logic               rx_sfd,
  output logic                    rx_stamp_valid,
  output logic [STAMP_W-1:0]      rx_stamp_value,

  // Interrupt
  output logic                    irq
);

  // ---------------------------------------------------------------
  // Timer
  // ---------------------------------------------------------------
  pft_tmr_if tmr_bus ();

  pft_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .aclk_en (aclk_en),
    .tmr     (tmr_bus.tmr)
  );

  // ---------------------------------------------------------------
  // Transmit stamping
  // ---------------------------------------------------------------
  logic [STAMP_W-1:0] pend_stamp_q, pend_stamp_d;
  logic               pend_req_q,   pend_req_d;
  logic [SEQ_W-1:0]   pend_seq_q,   pend_seq_d;
  logic               txv_q,        txv_d;
  logic [STAMP_W-1:0] txs_q,        txs_d;
  logic [SEQ_W-1:0]   txq_q,        txq_d;
  logic [STAT_W-1:0]  txt_q,        txt_d;
  logic [STAMP_W-1:0] held_q,       held_d;
  logic               held_set;

  always_comb begin
    pend_stamp_d = pend_stamp_q;
    pend_req_d   = pend_req_q;
    pend_seq_d   = pend_seq_q;
    txv_d        = 1'b0;
    txs_d        = txs_q;
    txq_d        = txq_q;
    txt_d        = txt_q;
    held_d       = held_q;
    held_set     = 1'b0;
    // Stamp is taken when the delimiter leaves; the request is the
    // client's marking of this frame.
    if (tx_sfd) begin
      pend_stamp_d = tmr_bus.count;
      pend_req_d   = tx_stamp_request;
      pend_seq_d   = tx_frame_seq;
    end
    // Every finished frame returns its record, flagged or not
    if (tx_frame_end) begin
      txv_d = 1'b1;
      txs_d = pend_stamp_q;
      txq_d = pend_seq_q;
      txt_d = tx_frame_status;
      txt_d[STAT_FLAGGED] = pend_req_q;
      // Only requested frames touch the held stamp
      if (pend_req_q) begin
        held_d   = pend_stamp_q;
        held_set = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_stamp_q <= STAMP_RST;
      pend_req_q   <= 1'b0;
      pend_seq_q   <= SEQ_RST;
      txv_q        <= 1'b0;
      txs_q        <= STAMP_RST;
      txq_q        <= SEQ_RST;
      txt_q        <= STAT_RST;
      held_q       <= STAMP_RST;
    end else if (aclk_en) begin
      pend_stamp_q <= pend_stamp_d;
      pend_req_q   <= pend_req_d;
      pend_seq_q   <= pend_seq_d;
      txv_q        <= txv_d;
      txs_q        <= txs_d;
      txq_q        <= txq_d;
      txt_q        <= txt_d;
      held_q       <= held_d;
    end
  end

  assign tx_stamp_valid  = txv_q;
  assign tx_stamp_value  = txs_q;
  assign tx_stamp_seq    = txq_q;
  assign tx_stamp_status = txt_q;

  // ---------------------------------------------------------------
  // Receive stamping
  // ---------------------------------------------------------------
  logic               rxv_q, rxv_d;
  logic [STAMP_W-1:0] rxs_q, rxs_d;

  always_comb begin
    rxv_d = rx_sfd;
    rxs_d = rxs_q;
    // Value stays until the next frame so DMA may copy it late
    if (rx_sfd) begin
      rxs_d = tmr_bus.count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxv_q <= 1'b0;
      rxs_q <= STAMP_RST;
    end else if (aclk_en) begin
      rxv_q <= rxv_d;
      rxs_q <= rxs_d;
    end
  end

  assign rx_stamp_valid = rxv_q;
  assign rx_stamp_value = rxs_q;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic               aw_hold_q, aw_hold_d;
  logic [AXI_AW-1:0]  awaddr_q,  awaddr_d;
  logic               w_hold_q,  w_hold_d;
  logic [AXI_DW-1:0]  wdata_q,   wdata_d;
  logic [AXI_SW-1:0]  wstrb_q,   wstrb_d;
  logic               awrdy_q,   awrdy_d;
  logic               wrdy_q,    wrdy_d;
  logic               bvalid_q,  bvalid_d;
  logic [1:0]         bresp_q,   bresp_d;
  logic               arrdy_q,   arrdy_d;
  logic               rvalid_q,  rvalid_d;
  logic [AXI_DW-1:0]  rdata_q,   rdata_d;
  logic [1:0]         rresp_q,   rresp_d;
  logic               wr_flags;
  logic               wr_mask;
  logic [EVT_W-1:0]   wr_bits;

  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d  = awaddr_q;
    w_hold_d  = w_hold_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_flags  = 1'b0;
    wr_mask   = 1'b0;
    wr_bits   = wdata_q[EVT_W-1:0];
    if (s_axi_awvalid && awrdy_q) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Commit only when the previous response has gone
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      unique case (awaddr_q)
        OFS_EVENT_FLAGS: wr_flags = wstrb_q[0];
        OFS_EVENT_MASK:  wr_mask  = wstrb_q[0];
        OFS_HELD_STAMP,
        OFS_TIMER_NOW:   ;
        default:         bresp_d  = RESP_SLVERR;
      endcase
    end
    awrdy_d = !aw_hold_d;
    wrdy_d  = !w_hold_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      awrdy_q   <= 1'b0;
      wrdy_q    <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (aclk_en) begin
      aw_hold_q <= aw_hold_d;
      awaddr_q  <= awaddr_d;
      w_hold_q  <= w_hold_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awrdy_q   <= awrdy_d;
      wrdy_q    <= wrdy_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Event flags, mask and interrupt
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] flags_q, flags_d;
  logic [EVT_W-1:0] mask_q,  mask_d;
  logic             irq_q,   irq_d;
  logic [EVT_W-1:0] ev_set;

  always_comb begin
    ev_set                  = '0;
    ev_set[EVT_STAMP_READY] = held_set;
    ev_set[EVT_TIMER]       = tmr_bus.wrap;
    // Write-one-to-clear; a new event in the same cycle survives
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_d & ~wr_bits;
    end
    flags_d = flags_d | ev_set;
    mask_d  = wr_mask ? wr_bits : mask_q;
    irq_d   = |(flags_q & mask_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= EVT_RST;
      mask_q  <= MASK_RST;
      irq_q   <= 1'b0;
    end else if (aclk_en) begin
      flags_q <= flags_d;
      mask_q  <= mask_d;
      irq_q   <= irq_d;
    end
  end

  assign irq = irq_q;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_comb begin
    arrdy_d  = arrdy_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
      arrdy_d  = 1'b1;
    end
    if (!rvalid_q && !arrdy_q) begin
      arrdy_d = 1'b1;
    end
    if (s_axi_arvalid && arrdy_q) begin
      arrdy_d  = 1'b0;
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      unique case (s_axi_araddr)
        OFS_EVENT_FLAGS: rdata_d[EVT_W-1:0] = flags_q;
        OFS_EVENT_MASK:  rdata_d[EVT_W-1:0] = mask_q;
        OFS_HELD_STAMP:  rdata_d = held_q;
        OFS_TIMER_NOW:   rdata_d = tmr_bus.count;
        default:         rresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (aclk_en) begin
      arrdy_q  <= arrdy_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule : pft_stamp

/* File: bench/pft_stamp_monitor.sv */
// Port-level checker for the frame timestamping unit
`timescale 1ns/1ps
module pft_stamp_chk
  import pft_pkg::*;
(
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Transmit side
  input wire logic               tx_sfd,
  input wire logic               tx_stamp_request,
  input wire logic [SEQ_W-1:0]   tx_frame_seq,
  input wire logic               tx_frame_end,
  input wire logic [STAT_W-1:0]  tx_frame_status,
  input wire logic               tx_stamp_valid,
  input wire logic [STAMP_W-1:0] tx_stamp_value,
  input wire logic [SEQ_W-1:0]   tx_stamp_seq,
  input wire logic [STAT_W-1:0]  tx_stamp_status,
  // Receive side
  input wire logic               rx_sfd,
  input wire logic               rx_stamp_valid,
  input wire logic [STAMP_W-1:0] rx_stamp_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Shadow timer and record in flight
  // ---------------------------------------------------------------
  // Assumes the clock enable stays high; a frozen timer is not modelled
  logic [STAMP_W-1:0] cnt_q, cap_ts_q, rec_ts_q;
  logic [SEQ_W-1:0]   cap_seq_q, rec_seq_q;
  logic               cap_req_q, rec_req_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= STAMP_RST;
      {cap_ts_q, cap_seq_q, cap_req_q} <= '0;
      {rec_ts_q, rec_seq_q, rec_req_q} <= '0;
    end else begin
      cnt_q <= cnt_q + STAMP_ONE;
      if (tx_sfd) {cap_ts_q, cap_seq_q, cap_req_q} <= {cnt_q, tx_frame_seq, tx_stamp_request};
      // End and next delimiter may share a cycle: the record keeps the old capture
      if (tx_frame_end) {rec_ts_q, rec_seq_q, rec_req_q} <= {cap_ts_q, cap_seq_q, cap_req_q};
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_txv_after_end: assert property (tx_frame_end |=> tx_stamp_valid)
    else $error("stamp record missing after frame end");
  a_txv_has_cause: assert property (tx_stamp_valid |-> $past(tx_frame_end))
    else $error("stamp record without frame end");
  a_tx_stamp_time: assert property (tx_stamp_valid |-> tx_stamp_value == rec_ts_q)
    else $error("transmit stamp not the delimiter time");
  a_tx_seq_pair: assert property (tx_stamp_valid |-> tx_stamp_seq == rec_seq_q)
    else $error("transmit sequence mismatch");
  a_stat_flag_bit: assert property (tx_stamp_valid |-> tx_stamp_status[5] == rec_req_q)
    else $error("status flag bit wrong");
  a_stat_rest: assert property (tx_stamp_valid |->
      ((tx_stamp_status ^ $past(tx_frame_status)) & 8'hdf) == 8'h00)
    else $error("status bits other than flag altered");
  a_tx_value_hold: assert property ($changed(tx_stamp_value) |-> tx_stamp_valid)
    else $error("transmit stamp changed between records");
  a_rx_stamp_time: assert property (rx_sfd |=>
      rx_stamp_valid && rx_stamp_value == $past(cnt_q))
    else $error("receive stamp late or wrong");
  a_rx_value_hold: assert property ($changed(rx_stamp_value) |-> rx_stamp_valid)
    else $error("receive stamp changed without frame");

  c_flagged: cover property (tx_stamp_valid && tx_stamp_status[5]);
  c_plain: cover property (tx_stamp_valid && !tx_stamp_status[5]);
  c_rx: cover property (rx_stamp_valid);
endmodule : pft_stamp_chk

bind pft_stamp pft_stamp_chk u_chk (
  .aclk, .aresetn, .tx_sfd, .tx_stamp_request, .tx_frame_seq, .tx_frame_end,
  .tx_frame_status, .tx_stamp_valid, .tx_stamp_value, .tx_stamp_seq,
  .tx_stamp_status, .rx_sfd, .rx_stamp_valid, .rx_stamp_value
);

/* File: bench/pft_mac_model.sv */
// MAC client and receive DMA stand-in facing the stamping unit
`timescale 1ns/1ps
module pft_mac_model
  import pft_pkg::*;
(
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Client strobes
  output logic                   tx_sfd,
  output logic                   tx_stamp_request,
  output logic [SEQ_W-1:0]       tx_frame_seq,
  output logic                   tx_frame_end,
  output logic [STAT_W-1:0]      tx_frame_status,
  output logic                   rx_sfd,
  // Receive DMA
  input wire logic               rx_stamp_valid,
  input wire logic [STAMP_W-1:0] rx_stamp_value
);
  logic [STAMP_W-1:0] cyc_q, sfd_cyc, rx_cyc, desc_stamp;

  initial begin
    {tx_sfd, tx_stamp_request, tx_frame_end, rx_sfd} = '0;
    tx_frame_seq = '0;
    tx_frame_status = '0;
  end

  always_ff @(posedge aclk) begin
    cyc_q <= aresetn ? cyc_q + STAMP_ONE : STAMP_RST;
    if (rx_stamp_valid) desc_stamp <= rx_stamp_value;
  end

  // Qualifiers are inverted outside their strobe so stale values cannot pass
  task automatic send(input logic r, input logic [SEQ_W-1:0] s,
                      input logic [STAT_W-1:0] st, input int g);
    @(posedge aclk);
    tx_sfd <= 1'b1;
    tx_stamp_request <= r;
    tx_frame_seq <= s;
    @(posedge aclk);
    sfd_cyc = cyc_q;
    tx_sfd <= 1'b0;
    tx_stamp_request <= ~r;
    tx_frame_seq <= ~s;
    repeat (g) @(posedge aclk);
    tx_frame_end <= 1'b1;
    tx_frame_status <= st;
    @(posedge aclk);
    tx_frame_end <= 1'b0;
    tx_frame_status <= ~st;
  endtask : send

  task automatic recv();
    @(posedge aclk);
    rx_sfd <= 1'b1;
    @(posedge aclk);
    rx_cyc = cyc_q;
    rx_sfd <= 1'b0;
  endtask : recv
endmodule : pft_mac_model

/* File: bench/tb_pft_stamp.sv */
// Self-checking bench for the frame timestamping unit
`timescale 1ns/1ps
module tb_pft_stamp;
  import pft_pkg::*;

  logic aclk, aresetn, tx_sfd, tx_stamp_request, tx_frame_end, rx_sfd;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tx_stamp_valid, rx_stamp_valid, irq;
  logic [AXI_AW-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [AXI_DW-1:0]  s_axi_wdata, s_axi_rdata;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [SEQ_W-1:0]   tx_frame_seq, tx_stamp_seq;
  logic [STAT_W-1:0]  tx_frame_status, tx_stamp_status;
  logic [STAMP_W-1:0] tx_stamp_value, rx_stamp_value;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;
  int                 seed;

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  pft_stamp dut (.aclk, .aresetn, .aclk_en(1'b1), .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .tx_sfd, .tx_stamp_request, .tx_frame_seq, .tx_frame_end,
    .tx_frame_status, .tx_stamp_valid, .tx_stamp_value, .tx_stamp_seq, .tx_stamp_status,
    .rx_sfd, .rx_stamp_valid, .rx_stamp_value, .irq);

  pft_mac_model mac (.aclk, .aresetn, .tx_sfd, .tx_stamp_request, .tx_frame_seq,
    .tx_frame_end, .tx_frame_status, .rx_sfd, .rx_stamp_valid, .rx_stamp_value);

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_mismatch++;
    $display("ERROR %0t wait ran out", $time);
    test_done();
  endtask : hang

  task automatic axw(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d,
                     output logic [1:0] r);
    logic aw, w, b;
    int n;
    {aw, w, b} = 3'h7;
    n = 0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (b && n < 64) begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (b && s_axi_bvalid) begin
        b = 1'b0;
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end
    if (b) hang();
  endtask : axw

  task automatic axr(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d,
                     output logic [1:0] r);
    logic ar, rd;
    int n;
    {ar, rd} = 2'b11;
    n = 0;
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    while (rd && n < 64) begin
      @(posedge aclk);
      n++;
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (rd && s_axi_rvalid) begin
        rd = 1'b0;
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    if (rd) hang();
  endtask : axr

  initial begin : main
    logic [AXI_DW-1:0]  d;
    logic [1:0]         r;
    logic [STAMP_W-1:0] held;
    logic [SEQ_W-1:0]   sq;
    logic [STAT_W-1:0]  st;
    logic               req, men;
    int                 g, n;
    seed = 38556;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    held = STAMP_RST;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      axr(AXI_AW'(4 * k), d, r);
      chk(d, 32'h0);
    end
    axr(8'h40, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axw(8'h40, 32'h3, r);
    chk(32'(r), 32'(RESP_SLVERR));
    // Data are taken one edge after the address, so the count is one behind
    axr(OFS_TIMER_NOW, d, r);
    chk(d, mac.cyc_q - STAMP_ONE);
    // Held stamp is read-only: the write answers OKAY and leaves it alone
    axw(OFS_HELD_STAMP, 32'h5a, r);
    chk(32'(r), 32'(RESP_OKAY));
    for (int i = 0; i < 12; i++) begin
      req = (i == 0) ? 1'b0 : 1'($random(seed));
      sq = SEQ_W'($random(seed));
      st = STAT_W'($random(seed));
      g = (i == 1) ? 0 : ($random(seed) & 7);
      men = (i < 8);
      // Last four frames run masked: flag must still set, line must stay low
      if (i == 0 || i == 8) axw(OFS_EVENT_MASK, {31'h0, men}, r);
      fork
        mac.send(req, sq, st, g);
        mac.recv();
      join
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (tx_stamp_valid !== 1'b1 && n < 8);
      if (tx_stamp_valid !== 1'b1) hang();
      chk(tx_stamp_value, mac.sfd_cyc);
      chk(32'(tx_stamp_seq), 32'(sq));
      chk(32'(tx_stamp_status), 32'({st[7:6], req, st[4:0]}));
      chk(mac.desc_stamp, mac.rx_cyc);
      if (req) held = mac.sfd_cyc;
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'(req & men));
      // Software order: flag first, then the held stamp
      axr(OFS_EVENT_FLAGS, d, r);
      chk(d, {31'h0, req});
      axr(OFS_HELD_STAMP, d, r);
      chk(d, held);
      axw(OFS_EVENT_FLAGS, 32'h1, r);
    end
    test_done();
  end
endmodule : tb_pft_stamp
